// file: logic/restart_seq_cfg.svh
`ifndef RESTART_SEQ_CFG_SVH
`define RESTART_SEQ_CFG_SVH
`define SHORT_HOLD_CYCLES 1024
`define LONG_HOLD_CYCLES 131072
`define OC_PULSE_LIMIT 7
`define QUAL_TIME_NS 30
`define CLK_PERIOD_NS 50
// pulse must stay high strictly longer than the qualify time
`define QUAL_CYCLES ((`QUAL_TIME_NS / `CLK_PERIOD_NS) + 1)
`endif

// file: logic/restart_seq_pkg.sv
package restart_seq_pkg;
  typedef enum {ST_HOLD, ST_WAIT_FB, ST_RUN, ST_BURST_OFF} seq_state_t;
  typedef enum {HOLD_SHORT, HOLD_LONG} hold_kind_t;
endpackage

// file: logic/pulse_qualifier.sv
`timescale 1ns/1ps
`include "restart_seq_cfg.svh"
// asserts a one-cycle pulse once the comparator has stayed high long enough
module pulse_qualifier #(
  parameter int QUAL = `QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmp_in,
  output logic qualified
);
  logic [7:0] run;
  logic [7:0] next_run;
  logic fired;
  logic next_fired;
  logic next_qualified;

  always_comb
  begin
    next_run = run;
    next_fired = fired;
    next_qualified = 1'b0;
    if (!cmp_in)
    begin
      next_run = 8'h00;
      next_fired = 1'b0;
    end
    else if (!fired)
    begin
      if (run + 8'h01 >= 8'(QUAL))
      begin
        next_qualified = 1'b1; // [RULE_10]
        next_fired = 1'b1;
      end
      else
      begin
        next_run = run + 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run <= 8'h00;
      fired <= 1'b0;
      qualified <= 1'b0;
    end
    else
    begin
      run <= next_run;
      fired <= next_fired;
      qualified <= next_qualified;
    end
  end
endmodule

// file: logic/llc_restart_fault_sequencer.sv
// Summary of operation
// RULE_01: power-up holds switches off 1024 cycles
// RULE_02: faults and restart hold 131072 cycles
// RULE_03: feedback pull-up asserted during any hold
// RULE_04: hold expiry releases pull-up, starts switching
// RULE_05: first cycle waits for feedback below 2V
// RULE_06: line monitor low or high sense: remote-off
// RULE_07: supply recovery uses only short hold
// RULE_08: seven consecutive low-threshold pulses restart
// RULE_09: single upper-threshold pulse restarts at once
// RULE_10: pulse counts only if over 30 ns
// RULE_11: burst train stops at upper threshold
// RULE_12: burst train restarts at lower threshold
// RULE_13: below upper threshold switch continuously
// RULE_14: hold counters tick at maximum frequency clock
// RULE_15: pulse counter clears on clean cycle, hold
// RULE_16: supply lockout resets whole sequencer
`timescale 1ns/1ps
`include "restart_seq_cfg.svh"
module llc_restart_fault_sequencer #(
  parameter int SHORT_HOLD = `SHORT_HOLD_CYCLES,
  parameter int LONG_HOLD = `LONG_HOLD_CYCLES,
  parameter int OC_LIMIT = `OC_PULSE_LIMIT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MAXIMUM_SWITCHING_FREQUENCY_TICK,
  input wire logic CYCLE_END,
  input wire logic SENSE_LOW_CMP,
  input wire logic SENSE_HIGH_CMP,
  input wire logic LINE_MONITOR_OK,
  input wire logic FB_BELOW_2V,
  input wire logic FREQ_AT_UPPER_BURST,
  input wire logic FREQ_AT_LOWER_BURST,
  output logic FB_PULLUP,
  output logic SWITCH_ENABLE,
  output logic HOLD_LONG_ACTIVE,
  output restart_seq_pkg::seq_state_t STATE
);
  import restart_seq_pkg::*;

  seq_state_t state;
  seq_state_t next_state;
  logic [17:0] hold_cnt;
  logic [17:0] next_hold_cnt;
  logic [17:0] hold_len;
  logic [17:0] next_hold_len;
  logic [3:0] oc_cnt;
  logic [3:0] next_oc_cnt;
  logic seen_pulse;
  logic next_seen_pulse;
  logic low_q;
  logic high_q;
  logic fault;
  logic hold_done;
  logic [17:0] hold_ticks;
  logic [17:0] next_hold_ticks;

  pulse_qualifier u_low_q (
    .clk(CLK),
    .rst(RST),
    .cmp_in(SENSE_LOW_CMP),
    .qualified(low_q)
  );

  pulse_qualifier u_high_q (
    .clk(CLK),
    .rst(RST),
    .cmp_in(SENSE_HIGH_CMP),
    .qualified(high_q)
  );

  assign hold_done = (state == ST_HOLD) && MAXIMUM_SWITCHING_FREQUENCY_TICK && (hold_cnt + 18'h00001 >= hold_len); // [RULE_14]
  assign fault = (state != ST_HOLD) && (high_q || !LINE_MONITOR_OK || // [RULE_06] [RULE_09]
    (low_q && (oc_cnt + 4'h1 >= 4'(OC_LIMIT)))); // [RULE_08]

  always_comb
  begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_hold_len = hold_len;
    next_oc_cnt = oc_cnt;
    next_seen_pulse = seen_pulse;
    if (fault)
    begin
      next_state = ST_HOLD;
      next_hold_cnt = 18'h00000;
      next_hold_len = 18'(LONG_HOLD); // [RULE_02]
      next_oc_cnt = 4'h0; // [RULE_15]
      next_seen_pulse = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_HOLD:
        begin
          next_oc_cnt = 4'h0; // [RULE_15]
          next_seen_pulse = 1'b0;
          if (hold_done)
            next_state = ST_WAIT_FB; // [RULE_04]
          else if (MAXIMUM_SWITCHING_FREQUENCY_TICK)
            next_hold_cnt = hold_cnt + 18'h00001; // [RULE_14]
        end
        ST_WAIT_FB:
        begin
          if (FB_BELOW_2V)
            next_state = ST_RUN; // [RULE_05]
        end
        ST_RUN, ST_BURST_OFF:
        begin
          if (low_q)
            next_seen_pulse = 1'b1;
          if (CYCLE_END)
          begin
            if (seen_pulse || low_q)
              next_oc_cnt = oc_cnt + 4'h1;
            else
              next_oc_cnt = 4'h0; // [RULE_15]
            next_seen_pulse = 1'b0;
          end
          if (state == ST_RUN && FREQ_AT_UPPER_BURST)
            next_state = ST_BURST_OFF; // [RULE_11] [RULE_13]
          else if (state == ST_BURST_OFF && FREQ_AT_LOWER_BURST)
            next_state = ST_RUN; // [RULE_12] [RULE_13]
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= ST_HOLD;
      hold_cnt <= 18'h00000;
      hold_len <= 18'(SHORT_HOLD); // [RULE_01] [RULE_07] [RULE_16]
      oc_cnt <= 4'h0;
      seen_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      hold_len <= next_hold_len;
      oc_cnt <= next_oc_cnt;
      seen_pulse <= next_seen_pulse;
    end
  end

  // independent tally of ticks seen in the current hold, checked against the hold length
  always_comb
  begin
    next_hold_ticks = 18'h00000;
    if (state == ST_HOLD)
    begin
      next_hold_ticks = hold_ticks;
      if (MAXIMUM_SWITCHING_FREQUENCY_TICK)
        next_hold_ticks = hold_ticks + 18'h00001;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      hold_ticks <= 18'h00000;
    else
      hold_ticks <= next_hold_ticks;
  end

  assign FB_PULLUP = (state == ST_HOLD); // [RULE_03]
  assign SWITCH_ENABLE = (state == ST_RUN); // [RULE_04]
  assign HOLD_LONG_ACTIVE = (state == ST_HOLD) && (hold_len == 18'(LONG_HOLD));
  assign STATE = state;

  sequence s_hold_end;
    state == ST_HOLD ##1 state == ST_WAIT_FB;
  endsequence

  property p_pullup_hold;
    @(posedge CLK) disable iff (RST) (state == ST_HOLD) |-> FB_PULLUP && !SWITCH_ENABLE;
  endproperty
  a_pullup_hold: assert property (p_pullup_hold) else $error("pull-up off during hold"); // [RULE_03]

  property p_reset_short;
    @(posedge CLK) $fell(RST) |-> state == ST_HOLD && hold_len == 18'(SHORT_HOLD);
  endproperty
  a_reset_short: assert property (p_reset_short) else $error("reset not short hold"); // [RULE_01]

  property p_fault_long;
    @(posedge CLK) disable iff (RST) fault |=> state == ST_HOLD && hold_len == 18'(LONG_HOLD) && hold_cnt == 18'h0;
  endproperty
  a_fault_long: assert property (p_fault_long) else $error("fault missed long hold"); // [RULE_02]

  property p_high_restart;
    @(posedge CLK) disable iff (RST) (high_q && state != ST_HOLD) |=> FB_PULLUP;
  endproperty
  a_high_restart: assert property (p_high_restart) else $error("upper pulse no restart"); // [RULE_09]

  property p_wait_fb;
    @(posedge CLK) disable iff (RST) (state == ST_WAIT_FB && !FB_BELOW_2V && LINE_MONITOR_OK && !high_q)
      |=> !SWITCH_ENABLE;
  endproperty
  a_wait_fb: assert property (p_wait_fb) else $error("switching before fb low"); // [RULE_05]

  property p_hold_expiry;
    @(posedge CLK) disable iff (RST) s_hold_end |-> $past(hold_cnt) + 18'h1 >= hold_len;
  endproperty
  a_hold_expiry: assert property (p_hold_expiry) else $error("hold ended early"); // [RULE_04]

  property p_oc_clear;
    @(posedge CLK) disable iff (RST) (state == ST_HOLD) |=> oc_cnt == 4'h0 || state != ST_HOLD;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("pulse count not cleared"); // [RULE_15]

  property p_burst_stop;
    @(posedge CLK) disable iff (RST) (state == ST_RUN && FREQ_AT_UPPER_BURST && !fault) |=> state == ST_BURST_OFF;
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("burst did not stop"); // [RULE_11]

  property p_burst_start;
    @(posedge CLK) disable iff (RST) (state == ST_BURST_OFF && FREQ_AT_LOWER_BURST && !fault) |=> SWITCH_ENABLE;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not restart"); // [RULE_12]

  property p_remote_off;
    @(posedge CLK) disable iff (RST) (!LINE_MONITOR_OK && state != ST_HOLD) |=> HOLD_LONG_ACTIVE;
  endproperty
  a_remote_off: assert property (p_remote_off) else $error("remote-off ignored"); // [RULE_06]

  sequence s_seventh_pulse;
    low_q && oc_cnt == 4'(OC_LIMIT - 1) && state != ST_HOLD;
  endsequence

  property p_hold_length;
    @(posedge CLK) disable iff (RST) s_hold_end |-> hold_ticks == hold_len;
  endproperty
  a_hold_length: assert property (p_hold_length) else $error("hold tick count wrong"); // [RULE_01] [RULE_02]

  property p_hold_tick;
    @(posedge CLK) disable iff (RST) (state == ST_HOLD && !MAXIMUM_SWITCHING_FREQUENCY_TICK) |=> state == ST_HOLD && $stable(hold_cnt);
  endproperty
  a_hold_tick: assert property (p_hold_tick) else $error("hold count moved without tick"); // [RULE_14]

  property p_hold_advance;
    @(posedge CLK) disable iff (RST) (state == ST_HOLD && MAXIMUM_SWITCHING_FREQUENCY_TICK && !hold_done)
      |=> hold_cnt == $past(hold_cnt) + 18'h00001;
  endproperty
  a_hold_advance: assert property (p_hold_advance) else $error("hold count missed tick"); // [RULE_14]

  property p_hold_refuse;
    @(posedge CLK) disable iff (RST) (state == ST_HOLD && !hold_done) |=> state == ST_HOLD && $stable(hold_len);
  endproperty
  a_hold_refuse: assert property (p_hold_refuse) else $error("hold cut short"); // [RULE_02]

  property p_hold_release;
    @(posedge CLK) disable iff (RST) hold_done |=> state == ST_WAIT_FB && !FB_PULLUP && !SWITCH_ENABLE;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold expiry not released"); // [RULE_04]

  property p_reset_clear;
    @(posedge CLK) RST |=> state == ST_HOLD && hold_cnt == 18'h00000 && oc_cnt == 4'h0
      && hold_len == 18'(SHORT_HOLD);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("lockout did not clear"); // [RULE_16] [RULE_07]

  property p_fault_outputs;
    @(posedge CLK) disable iff (RST) fault |=> FB_PULLUP && !SWITCH_ENABLE;
  endproperty
  a_fault_outputs: assert property (p_fault_outputs) else $error("fault left switching on"); // [RULE_03]

  property p_fb_release;
    @(posedge CLK) disable iff (RST) (state == ST_WAIT_FB && FB_BELOW_2V && !fault) |=> SWITCH_ENABLE;
  endproperty
  a_fb_release: assert property (p_fb_release) else $error("no switching after fb low"); // [RULE_05]

  property p_qual_source;
    @(posedge CLK) disable iff (RST) (!low_q || $past(SENSE_LOW_CMP)) && (!high_q || $past(SENSE_HIGH_CMP));
  endproperty
  a_qual_source: assert property (p_qual_source) else $error("pulse qualified without comparator"); // [RULE_10]

  property p_qual_once;
    @(posedge CLK) disable iff (RST) low_q |=> !low_q;
  endproperty
  a_qual_once: assert property (p_qual_once) else $error("pulse counted twice"); // [RULE_10]

  property p_oc_clean;
    @(posedge CLK) disable iff (RST) ((state == ST_RUN || state == ST_BURST_OFF) && CYCLE_END
      && !seen_pulse && !low_q && !fault) |=> oc_cnt == 4'h0;
  endproperty
  a_oc_clean: assert property (p_oc_clean) else $error("clean cycle kept count"); // [RULE_15]

  property p_oc_count;
    @(posedge CLK) disable iff (RST) ((state == ST_RUN || state == ST_BURST_OFF) && CYCLE_END
      && (seen_pulse || low_q) && !fault) |=> oc_cnt == $past(oc_cnt) + 4'h1;
  endproperty
  a_oc_count: assert property (p_oc_count) else $error("pulse cycle not counted"); // [RULE_08]

  property p_oc_bound;
    @(posedge CLK) disable iff (RST) oc_cnt < 4'(OC_LIMIT);
  endproperty
  a_oc_bound: assert property (p_oc_bound) else $error("pulse count passed limit"); // [RULE_08]

  property p_seventh;
    @(posedge CLK) disable iff (RST) s_seventh_pulse |=> HOLD_LONG_ACTIVE && hold_cnt == 18'h00000;
  endproperty
  a_seventh: assert property (p_seventh) else $error("seventh pulse no restart"); // [RULE_08]

  property p_run_steady;
    @(posedge CLK) disable iff (RST) (state == ST_RUN && !FREQ_AT_UPPER_BURST && !fault) |=> state == ST_RUN;
  endproperty
  a_run_steady: assert property (p_run_steady) else $error("continuous switching broke"); // [RULE_13]

  property p_burst_wait;
    @(posedge CLK) disable iff (RST) (state == ST_BURST_OFF && !FREQ_AT_LOWER_BURST && !fault)
      |=> state == ST_BURST_OFF;
  endproperty
  a_burst_wait: assert property (p_burst_wait) else $error("burst restarted early"); // [RULE_12]
endmodule

// file: dv/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model #(
  parameter int TICK_DIV = 4,
  parameter int CYC_DIV = 8
) (
  input wire logic clk,
  input wire logic rst,
  output logic maximum_switching_frequency_tick,
  output logic cycle_end
);
  int tick_cnt = 0;
  int cyc_cnt = 0;
  initial
  begin
    maximum_switching_frequency_tick = 1'b0;
    cycle_end = 1'b0;
  end
  // free-running oscillator strobes, quiet during lockout
  always @(posedge clk)
  begin
    tick_cnt <= (rst || tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
    cyc_cnt <= (rst || cyc_cnt == CYC_DIV - 1) ? 0 : cyc_cnt + 1;
    maximum_switching_frequency_tick <= !rst && tick_cnt == TICK_DIV - 1;
    cycle_end <= !rst && cyc_cnt == CYC_DIV - 1;
  end
endmodule

// file: dv/llc_restart_fault_sequencer_bench.sv
`timescale 1ns/1ps
module llc_restart_fault_sequencer_bench;
  import restart_seq_pkg::*;
  localparam int SH = 4;
  localparam int LH = 16;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic MAXIMUM_SWITCHING_FREQUENCY_TICK;
  logic CYCLE_END;
  logic [1:0] sense = 2'h0;
  logic [1:0] freq = 2'h0;
  logic line_ok = 1'b1;
  logic fb_low = 1'b0;
  logic FB_PULLUP;
  logic SWITCH_ENABLE;
  logic HOLD_LONG_ACTIVE;
  seq_state_t STATE;
  int err_count = 0;
  int comparisons = 0;
  int ticks = 0;
  always #25 CLK = ~CLK;
  power_stage_model stage (.clk(CLK), .rst(RST), .maximum_switching_frequency_tick(MAXIMUM_SWITCHING_FREQUENCY_TICK), .cycle_end(CYCLE_END));
  llc_restart_fault_sequencer #(.SHORT_HOLD(SH), .LONG_HOLD(LH), .OC_LIMIT(7)) dut (.CLK(CLK), .RST(RST),
    .MAXIMUM_SWITCHING_FREQUENCY_TICK(MAXIMUM_SWITCHING_FREQUENCY_TICK), .CYCLE_END(CYCLE_END), .SENSE_LOW_CMP(sense[0]), .SENSE_HIGH_CMP(sense[1]),
    .LINE_MONITOR_OK(line_ok), .FB_BELOW_2V(fb_low), .FREQ_AT_UPPER_BURST(freq[0]),
    .FREQ_AT_LOWER_BURST(freq[1]), .FB_PULLUP(FB_PULLUP), .SWITCH_ENABLE(SWITCH_ENABLE),
    .HOLD_LONG_ACTIVE(HOLD_LONG_ACTIVE), .STATE(STATE));
  // ticks seen while holding
  always @(posedge CLK)
    if (STATE == ST_HOLD && MAXIMUM_SWITCHING_FREQUENCY_TICK)
      ticks++;
  task automatic end_sim();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_st(input seq_state_t s);
    int n;
    n = 0;
    while (STATE !== s && n < 400)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    check(STATE, s);
  endtask
  task automatic pulse(input int idx, input int len);
    @(posedge CLK);
    sense[idx] <= 1'b1;
    repeat (len) @(posedge CLK);
    sense[idx] <= 1'b0;
  endtask
  task automatic low_cycles(input int n);
    repeat (n)
    begin
      @(posedge CLK iff CYCLE_END);
      pulse(0, 2);
    end
  endtask
  task automatic hold_then_run(input int len, input logic lng);
    wait_st(ST_HOLD);
    check(FB_PULLUP, 1'b1);
    check(HOLD_LONG_ACTIVE, lng);
    wait_st(ST_WAIT_FB);
    check(ticks, len);
    check(FB_PULLUP, 1'b0);
    wait_st(ST_RUN);
  endtask
  task automatic t_powerup();
    #1;
    check(SWITCH_ENABLE, 1'b0);
    wait_st(ST_WAIT_FB);
    repeat (3) @(posedge CLK);
    #1;
    check(STATE, ST_WAIT_FB);
    check(SWITCH_ENABLE, 1'b0);
    check(ticks, SH);
    @(posedge CLK);
    fb_low <= 1'b1;
    wait_st(ST_RUN);
    check(SWITCH_ENABLE, 1'b1);
  endtask
  task automatic t_line();
    ticks = 0;
    @(posedge CLK);
    line_ok <= 1'b0;
    @(posedge CLK);
    line_ok <= 1'b1;
    hold_then_run(LH, 1'b1);
  endtask
  task automatic t_sense_high();
    ticks = 0;
    pulse(1, 1);
    hold_then_run(LH, 1'b1);
    check(STATE, ST_RUN);
    ticks = 0;
    pulse(1, 2);
    hold_then_run(LH, 1'b1);
  endtask
  task automatic t_sense_low();
    low_cycles(6);
    repeat (2) @(posedge CLK iff CYCLE_END);
    low_cycles(6);
    #1;
    check(STATE, ST_RUN);
    ticks = 0;
    low_cycles(1);
    hold_then_run(LH, 1'b1);
  endtask
  task automatic t_burst();
    @(posedge CLK);
    freq <= 2'h1;
    wait_st(ST_BURST_OFF);
    check(SWITCH_ENABLE, 1'b0);
    @(posedge CLK);
    freq <= 2'h0;
    repeat (3) @(posedge CLK);
    #1;
    check(STATE, ST_BURST_OFF);
    @(posedge CLK);
    freq <= 2'h2;
    wait_st(ST_RUN);
    @(posedge CLK);
    freq <= 2'h0;
    repeat (5) @(posedge CLK);
    #1;
    check(SWITCH_ENABLE, 1'b1);
    @(posedge CLK);
    freq <= 2'h1;
    wait_st(ST_BURST_OFF);
    @(posedge CLK);
    freq <= 2'h0;
  endtask
  task automatic t_reset();
    @(posedge CLK);
    line_ok <= 1'b0;
    @(posedge CLK);
    line_ok <= 1'b1;
    wait_st(ST_HOLD);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    #1;
    ticks = 0;
    hold_then_run(SH, 1'b0);
  endtask
  initial
  begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    t_powerup();
    t_line();
    t_sense_high();
    t_sense_low();
    t_burst();
    t_reset();
    end_sim();
  end
  initial
  begin
    #(20000 * 50);
    err_count++;
    end_sim();
  end
endmodule
